//--- rtl/sgcl_pkg.sv
// Shared constants for the serial gain code loader
package sgcl_pkg;
   localparam int SHIFT_W = 6;
   localparam logic [5:0] CODE_MIN = 6'h01;
   localparam logic [5:0] CODE_MAX = 6'h3c;
   localparam logic [5:0] CODE_RESET = 6'h01;
   // Gain in half-dB units: 2 * code - 53
   localparam logic signed [7:0] GAIN_OFFSET = 8'sh35;
   localparam logic signed [7:0] GAIN_RESET = 8'shcd;
   localparam logic [1:0] SYNC_RESET = 2'h0;
endpackage : sgcl_pkg

//--- rtl/sgcl_shifter.sv
// Link-domain six-bit gain word shift register
module sgcl_shifter #(
   parameter int SHIFT_W = sgcl_pkg::SHIFT_W
) (
   input wire logic shift_clock_i,
   input wire logic resetn_i,
   input wire logic load_enable_n_i,
   input wire logic serial_word_in_i,
   output logic [SHIFT_W-1:0] word_o
);
   import sgcl_pkg::*;

   typedef struct packed {
      logic [SHIFT_W-1:0] word;
   } sgcl_shift_state_t;

   sgcl_shift_state_t st_reg;
   sgcl_shift_state_t st_next;

   if (SHIFT_W != 6) begin : g_width_check
      $error("Shift width must be six");
   end

   always_comb begin
      st_next = st_reg;
      // Shift MSB first while enable is low; only the last six bits remain
      if (!load_enable_n_i) begin
         st_next.word = {st_reg.word[SHIFT_W-2:0], serial_word_in_i}; // [RULE2] [RULE3] [RULE4] [RULE15]
      end
   end

   always_ff @(posedge shift_clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign word_o = st_reg.word;

   sequence six_shifts;
      (!load_enable_n_i) [*6];
   endsequence

   shift_step_a: assert property (@(posedge shift_clock_i) disable iff (!resetn_i) // [RULE4]
      !load_enable_n_i |=> word_o == {$past(word_o[SHIFT_W-2:0]), $past(serial_word_in_i)})
      else $error("Word did not shift in the data bit");

   shift_hold_a: assert property (@(posedge shift_clock_i) disable iff (!resetn_i) // [RULE11]
      load_enable_n_i |=> $stable(word_o))
      else $error("Word changed while loading was closed");

   last_six_a: assert property (@(posedge shift_clock_i) disable iff (!resetn_i) // [RULE15]
      six_shifts |=> (word_o[0] == $past(serial_word_in_i, 1))
         && (word_o[SHIFT_W-1] == $past(serial_word_in_i, 6)))
      else $error("Word does not hold the last six bits MSB first");
endmodule : sgcl_shifter

//--- rtl/sgcl_top.sv
// Serial gain code loader with transmit gate and sleep control
// Overview of operation
// RULE1: Host holds load enable low while shifting.
// RULE2: Gain bits captured in six-bit shift register.
// RULE3: Words travel MSB first; last bit is LSB.
// RULE4: Shift data on shift clock rise while enabled.
// RULE5: Upper two bits of eight-bit words dropped.
// RULE6: Codes 1 through 60 are distinct settings.
// RULE7: Codes 61 to 63 apply code 60.
// RULE8: Each code step adds one dB, linearly.
// RULE9: Transmit gate low blocks, high permits transmission.
// RULE10: Host drives serial data and shift clock.
// RULE11: Enable rise applies word, stops further shifting.
// RULE12: Enable fall keeps gain, reopens shift register.
// RULE13: Gain code 1 applied after power-up.
// RULE14: Sleep low powers down, high powers up.
// RULE15: Only the last six bits are kept.
module sgcl_top (
   input wire logic clock_i,
   input wire logic resetn_i,
   input wire logic shift_clock_i,
   input wire logic load_enable_n_i,
   input wire logic serial_word_in_i,
   input wire logic transmit_gate_i,
   input wire logic sleep_n_i,
   output logic [sgcl_pkg::SHIFT_W-1:0] gain_code_o,
   output logic signed [7:0] gain_half_db_o,
   output logic tx_active_o,
   output logic powered_o
);
   import sgcl_pkg::*;

   typedef struct packed {
      logic en_s1;
      logic en_s2;
      logic en_prev;
      logic gate_s1;
      logic gate_s2;
      logic sleep_s1;
      logic sleep_s2;
      logic [SHIFT_W-1:0] code;
      logic signed [7:0] half_db;
      logic tx_active;
      logic powered;
   } sgcl_top_state_t;

   logic [1:0] rst_sync_reg;
   logic rst_n;
   logic [SHIFT_W-1:0] link_word;
   logic load_rise;
   sgcl_top_state_t st_reg;
   sgcl_top_state_t st_next;

   function automatic logic [SHIFT_W-1:0] sgcl_decode(input logic [SHIFT_W-1:0] w);
      logic [SHIFT_W-1:0] r;
      r = w;
      if (w > CODE_MAX) begin
         r = CODE_MAX; // [RULE7]
      end else if (w < CODE_MIN) begin
         r = CODE_MIN;
      end
      return r;
   endfunction : sgcl_decode

   // Reset release through two flops
   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rst_sync_reg <= SYNC_RESET;
      end else begin
         rst_sync_reg <= {rst_sync_reg[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_reg[1];

   // Host drives data and shift clock on the link side
   sgcl_shifter #(.SHIFT_W(SHIFT_W)) u_shifter ( // [RULE10]
      .shift_clock_i(shift_clock_i),
      .resetn_i(rst_n),
      .load_enable_n_i(load_enable_n_i), // [RULE1]
      .serial_word_in_i(serial_word_in_i),
      .word_o(link_word)
   );

   assign load_rise = st_reg.en_s2 & ~st_reg.en_prev;

   always_comb begin
      st_next = st_reg;
      st_next.en_s1 = load_enable_n_i;
      st_next.en_s2 = st_reg.en_s1;
      st_next.en_prev = st_reg.en_s2;
      st_next.gate_s1 = transmit_gate_i;
      st_next.gate_s2 = st_reg.gate_s1;
      st_next.sleep_s1 = sleep_n_i;
      st_next.sleep_s2 = st_reg.sleep_s1;
      // Word is frozen once enable is high, so it is safe to sample here
      if (load_rise) begin
         st_next.code = sgcl_decode(link_word); // [RULE5] [RULE6] [RULE11] [RULE12]
      end
      st_next.half_db = $signed({1'b0, st_next.code, 1'b0}) - GAIN_OFFSET; // [RULE8]
      st_next.powered = st_reg.sleep_s2; // [RULE14]
      st_next.tx_active = st_reg.gate_s2 & st_reg.sleep_s2; // [RULE9]
   end

   always_ff @(posedge clock_i or negedge rst_n) begin
      if (!rst_n) begin
         st_reg <= '0;
         st_reg.en_s1 <= 1'b1;
         st_reg.en_s2 <= 1'b1;
         st_reg.en_prev <= 1'b1;
         st_reg.code <= CODE_RESET; // [RULE13]
         st_reg.half_db <= GAIN_RESET;
      end else begin
         st_reg <= st_next;
      end
   end

   assign gain_code_o = st_reg.code;
   assign gain_half_db_o = st_reg.half_db;
   assign tx_active_o = st_reg.tx_active;
   assign powered_o = st_reg.powered;

   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (!rst_n);

   sequence gate_drop;
      $fell(st_reg.gate_s2);
   endsequence

   sequence enable_pin_rise;
      $rose(load_enable_n_i);
   endsequence

   sequence enable_rise_seen;
      st_reg.en_s2 && !st_reg.en_prev;
   endsequence

   sequence gate_open;
      st_reg.gate_s2 && st_reg.sleep_s2;
   endsequence

   code_range_a: assert property ( // [RULE6]
      gain_code_o >= CODE_MIN && gain_code_o <= CODE_MAX)
      else $error("Applied gain code out of range");

   clamp_high_a: assert property ( // [RULE7]
      load_rise && link_word > CODE_MAX |=> gain_code_o == CODE_MAX)
      else $error("High code not clamped to maximum");

   load_apply_a: assert property ( // [RULE11]
      load_rise && link_word >= CODE_MIN && link_word <= CODE_MAX
         |=> gain_code_o == $past(link_word))
      else $error("Valid word not applied on enable rise");

   gain_hold_a: assert property ( // [RULE12]
      !load_rise |=> $stable(gain_code_o))
      else $error("Gain changed without enable rise");

   gain_map_a: assert property ( // [RULE8]
      int'(gain_half_db_o) == int'(GAIN_RESET) + 2 * (int'(gain_code_o) - int'(CODE_RESET)))
      else $error("Gain does not follow one dB per code");

   power_code_a: assert property ( // [RULE13]
      $rose(rst_n) |-> gain_code_o == CODE_RESET)
      else $error("Gain code not one after reset");

   tx_block_a: assert property ( // [RULE9]
      gate_drop |=> !tx_active_o)
      else $error("Transmit not blocked after gate low");

   sleep_down_a: assert property ( // [RULE14]
      !st_reg.sleep_s2 |=> !powered_o && !tx_active_o)
      else $error("Device not powered down in sleep");

   pin_to_power_a: assert property ( // [RULE14]
      $rose(sleep_n_i) ##1 sleep_n_i [*2] |=> powered_o)
      else $error("Device not powered up after sleep release");

   code_zero_a: assert property ( // [RULE6]
      load_rise && link_word < CODE_MIN |=> gain_code_o == CODE_MIN)
      else $error("Code zero not applied as lowest code");

   tx_permit_a: assert property ( // [RULE9]
      gate_open |=> tx_active_o)
      else $error("Transmit not permitted with gate high and awake");

   power_up_a: assert property ( // [RULE14]
      st_reg.sleep_s2 |=> powered_o)
      else $error("Device not powered up with sleep high");

   load_latency_a: assert property ( // [RULE11]
      enable_pin_rise |-> ##[1:3] enable_rise_seen)
      else $error("Enable rise not detected in time");

   word_frozen_a: assert property ( // [RULE11]
      enable_rise_seen |-> $stable(link_word))
      else $error("Shifted word moving while it is applied");

   enable_fall_hold_a: assert property ( // [RULE12]
      $fell(st_reg.en_s2) |=> $stable(gain_code_o))
      else $error("Gain changed on enable fall");

   code_hold_open_a: assert property ( // [RULE12]
      !st_reg.en_s2 |=> $stable(gain_code_o))
      else $error("Gain changed while loading is open");

   step_one_db_a: assert property ( // [RULE8]
      gain_code_o == 6'($past(gain_code_o) + 6'h01)
         |-> gain_half_db_o == 8'($past(gain_half_db_o) + 8'sh02))
      else $error("Gain step is not one dB per code");

   tx_follow_a: assert property ( // [RULE9]
      tx_active_o |-> $past(transmit_gate_i, 3) && $past(sleep_n_i, 3))
      else $error("Transmit active without gate and wake");

   power_follow_a: assert property ( // [RULE14]
      powered_o |-> $past(sleep_n_i, 3))
      else $error("Powered without sleep input high");

   reset_state_a: assert property ( // [RULE13]
      $rose(rst_n) |-> gain_half_db_o == GAIN_RESET && !powered_o && !tx_active_o)
      else $error("Outputs not at power-up state after reset");
endmodule : sgcl_top

//--- bench/sgcl_host_model.sv
// Host model driving the serial gain load lines
module sgcl_host_model (
   output logic shift_clock_o,
   output logic load_enable_n_o,
   output logic serial_word_in_o
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      shift_clock_o = 1'b0;
      load_enable_n_o = 1'b1;
      serial_word_in_o = 1'b0;
   end
   task automatic send(input logic [7:0] word, input int nbits);
      #7 load_enable_n_o = 1'b0;
      for (int i = nbits - 1; i >= 0; i--) begin
         serial_word_in_o = word[i];
         #24 shift_clock_o = 1'b1;
         #24 shift_clock_o = 1'b0;
      end
      #24 load_enable_n_o = 1'b1;
      serial_word_in_o = ~serial_word_in_o;
   endtask : send
   task automatic stray(input int npulses);
      for (int i = 0; i < npulses; i++) begin
         serial_word_in_o = ~serial_word_in_o;
         #24 shift_clock_o = 1'b1;
         #24 shift_clock_o = 1'b0;
      end
   endtask : stray
endmodule : sgcl_host_model

//--- bench/tb_top.sv
// Testbench for the serial gain code loader
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import sgcl_pkg::*;
   logic clock_i, resetn_i, transmit_gate_i, sleep_n_i, sclk, len_n, sdat, tx, pwr;
   logic [SHIFT_W-1:0] code;
   logic signed [7:0] half_db;
   int n_mismatch = 0;
   int cmp_count = 0;
   int cycles = 0;
   sgcl_host_model host (.shift_clock_o(sclk), .load_enable_n_o(len_n),
      .serial_word_in_o(sdat));
   sgcl_top uut (.clock_i(clock_i), .resetn_i(resetn_i), .shift_clock_i(sclk),
      .load_enable_n_i(len_n), .serial_word_in_i(sdat), .transmit_gate_i(transmit_gate_i),
      .sleep_n_i(sleep_n_i), .gain_code_o(code), .gain_half_db_o(half_db),
      .tx_active_o(tx), .powered_o(pwr));
   initial begin
      clock_i = 1'b0;
      forever #12.5 clock_i = ~clock_i;
   end
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic finish_test();
      if (n_mismatch == 0 && cmp_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : finish_test
   always @(posedge clock_i) begin
      cycles++;
      if (cycles == 2000) begin
         n_mismatch++;
         finish_test();
      end
   end
   task automatic load(input logic [7:0] w, input int n, input logic [5:0] exp);
      host.send(w, n);
      repeat (8) @(posedge clock_i);
      @(negedge clock_i);
      check(8'(code), 8'(exp));
      check(half_db, 8'(2 * int'(exp) - 53));
   endtask : load
   task automatic test_codes();
      logic [5:0] sent [9] = '{6'h01, 6'h02, 6'h1e, 6'h3b, 6'h3c, 6'h3d, 6'h3e, 6'h3f, 6'h00};
      logic [5:0] want [9] = '{6'h01, 6'h02, 6'h1e, 6'h3b, 6'h3c, 6'h3c, 6'h3c, 6'h3c, 6'h01};
      foreach (sent[i])
         load({2'h0, sent[i]}, 6, want[i]);
   endtask : test_codes
   task automatic test_eight_bit();
      load(8'h4b, 8, 6'h0b);
      load(8'hc5, 8, 6'h05);
      load(8'hff, 8, 6'h3c);
   endtask : test_eight_bit
   task automatic test_hold();
      fork
         load(8'h2a, 6, 6'h2a);
         begin
            wait (len_n === 1'b0);
            repeat (6) @(posedge clock_i);
            @(negedge clock_i);
            check(8'(code), 8'h3c);
         end
      join
   endtask : test_hold
   task automatic test_refuse();
      load(8'h15, 6, 6'h15);
      host.stray(3);
      load(8'h00, 1, 6'h2a);
   endtask : test_refuse
   task automatic set_lines(input logic g, input logic s, input logic etx, input logic ep);
      @(posedge clock_i);
      transmit_gate_i <= g;
      sleep_n_i <= s;
      repeat (4) @(posedge clock_i);
      @(negedge clock_i);
      check(8'(tx), 8'(etx));
      check(8'(pwr), 8'(ep));
   endtask : set_lines
   initial begin
      resetn_i = 1'b0;
      transmit_gate_i = 1'b0;
      sleep_n_i = 1'b1;
      repeat (4) @(posedge clock_i);
      resetn_i <= 1'b1;
      repeat (4) @(posedge clock_i);
      @(negedge clock_i);
      check(8'(code), 8'h01);
      check(half_db, 8'hcd);
      set_lines(1'b1, 1'b1, 1'b1, 1'b1);
      set_lines(1'b0, 1'b1, 1'b0, 1'b1);
      set_lines(1'b1, 1'b0, 1'b0, 1'b0);
      set_lines(1'b1, 1'b1, 1'b1, 1'b1);
      test_codes();
      test_eight_bit();
      test_hold();
      test_refuse();
      finish_test();
   end
endmodule : tb_top
